// ==== verification/pmon_link_assertions.sv ====
// concurrent checks on the wires between host and device ends
`timescale 1ns/10ps
module pmon_link_assertions (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  // ----------------------------------------
  // frame tracking from the raw wires
  // ----------------------------------------
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;
    logic rd;
    logic ign;
  } mon_s;
  mon_s mon_reg;
  mon_s mon_next;
  logic hi;
  // high for a second sample, so the bit count has settled
  assign hi = scl && mon_reg.scl_q;
  always_comb
  begin
    mon_next = mon_reg;
    mon_next.scl_q = scl;
    mon_next.sda_q = sda;
    if (hi && mon_reg.sda_q && !sda)
    begin
      mon_next.cnt = 4'h0;
      mon_next.first = 1'h1;
      mon_next.rd = 1'h0;
      mon_next.ign = 1'h0;
    end
    else if (scl && !mon_reg.scl_q)
    begin
      mon_next.cnt = (mon_reg.cnt == 4'h9) ? 4'h1 : mon_reg.cnt + 4'h1;
      if (mon_reg.cnt < 4'h8)
        mon_next.sh = {mon_reg.sh[6:0], sda};
      if (mon_reg.cnt == 4'h7 && mon_reg.first)
        mon_next.rd = sda;
      if (mon_reg.cnt == 4'h9)
        mon_next.first = 1'h0;
    end
    else if (hi && mon_reg.cnt == 4'h9 && mon_reg.first && sda)
      mon_next.ign = 1'h1;
  end
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      mon_reg <= '0;
    else
      mon_reg <= mon_next;
  end
  // ----------------------------------------
  // assertions and covers
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  AST_DEV_PULL_ONLY: assert property (sda_s_o == 1'h0)
    else $error("device drives sda high");
  AST_HOST_PULL_ONLY: assert property (!sda_m_o && !scl_o)
    else $error("host drives a line high");
  AST_DEV_STABLE_HIGH: assert property
    (sda_s_oe && $rose(scl) |-> sda_s_oe [*8])
    else $error("device released sda while scl high");
  AST_DEV_CHANGE_LOW: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("device changed sda while scl high");
  AST_ADDR_LISTEN: assert property
    (hi && mon_reg.first && mon_reg.cnt < 4'h9 |-> !sda_s_oe)
    else $error("device drove sda during address bits");
  AST_FOREIGN_NO_ACK: assert property
    (hi && mon_reg.first && mon_reg.cnt == 4'h9 &&
     mon_reg.sh[7:3] != 5'h0b |-> !sda_s_oe)
    else $error("device acked a foreign address");
  AST_IDLE_AFTER_NACK: assert property (mon_reg.ign |-> !sda_s_oe)
    else $error("device drove sda after address not acked");
  AST_WRITE_ACK_ONLY: assert property
    (hi && !mon_reg.rd && !mon_reg.first && mon_reg.cnt < 4'h9
     |-> !sda_s_oe)
    else $error("device drove sda in a written data bit");
  AST_READ_ACK_FREE: assert property
    (hi && mon_reg.rd && !mon_reg.first && mon_reg.cnt == 4'h9
     |-> !sda_s_oe)
    else $error("device drove sda in master acknowledge slot");
  COV_ADDR_ACK: cover property
    (hi && mon_reg.first && mon_reg.cnt == 4'h9 && sda_s_oe);
  COV_READ_DRIVE: cover property (hi && mon_reg.rd && sda_s_oe);
  COV_NACKED: cover property (mon_reg.ign && scl_oe && sda_m_oe);
endmodule

// ==== verification/power_monitor_i2c_slave_alert_test.sv ====
// self-checking bench joining the host and device ends of the link
`timescale 1ns/10ps
module power_monitor_i2c_slave_alert_test;
  import pmon_pkg::*;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic [1:0] adr_sel = 2'h0;
  logic over = 1'h0;
  logic clr_n = 1'h1;
  logic supply_undervoltage_lockout = 1'h0;
  logic [11:0] volt = 12'ha5c;
  logic [11:0] curr = 12'h3e7;
  logic req = 1'h0;
  logic [6:0] req_addr = 7'h00;
  logic req_read = 1'h0;
  byte_t req_data = 8'h00;
  logic [1:0] req_len = 2'h0;
  logic alert_o, alert_oe, cmd_stb, busy, done, nack, rd_valid;
  byte_t cmd, rd_data;
  byte_t got [3];
  logic got_nack;
  logic [6:0] own;
  int stb_seen = 0;
  int miscompares = 0;
  int comparisons = 0;
  pmon_link_if pmon_link_if_i ();
  // long conversion so a read can land inside it; short scl half period
  pmon_device #(.CONV_CYCLES(400)) pmon_device_i (.MCLK(mclk),
    .RESET_N(reset_n), .LINK(pmon_link_if_i), .ADR_SEL(adr_sel),
    .OVERCURRENT(over), .LATCH_CLEAR_N(clr_n),
    .SUPPLY_UNDERVOLTAGE_LOCKOUT(supply_undervoltage_lockout), .VOLT_SAMPLE(volt),
    .CURR_SAMPLE(curr), .ALERT_O(alert_o), .ALERT_OE(alert_oe),
    .COMMAND(cmd), .COMMAND_STB(cmd_stb));
  pmon_host #(.HALF(8)) pmon_host_i (.MCLK(mclk), .RESET_N(reset_n),
    .LINK(pmon_link_if_i), .REQ(req), .REQ_ADDR(req_addr),
    .REQ_READ(req_read), .REQ_DATA(req_data), .REQ_LEN(req_len),
    .BUSY(busy), .DONE(done), .NACK(nack), .RD_DATA(rd_data),
    .RD_VALID(rd_valid));
  pmon_link_assertions pmon_link_assertions_i (.MCLK(mclk),
    .RESET_N(reset_n), .scl(pmon_link_if_i.scl), .sda(pmon_link_if_i.sda),
    .scl_o(pmon_link_if_i.scl_o), .scl_oe(pmon_link_if_i.scl_oe),
    .sda_m_o(pmon_link_if_i.sda_m_o), .sda_m_oe(pmon_link_if_i.sda_m_oe),
    .sda_s_o(pmon_link_if_i.sda_s_o), .sda_s_oe(pmon_link_if_i.sda_s_oe));
  always #20 mclk = ~mclk;
  always @(negedge mclk)
    if (cmd_stb === 1'h1)
      stb_seen++;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task xfer(input logic [6:0] a, input logic rd, input byte_t d,
    input logic [1:0] len);
    int n;
    int k;
    n = 0;
    @(negedge mclk);
    req = 1'h1;
    req_addr = a;
    req_read = rd;
    req_data = d;
    req_len = len;
    for (k = 0; k < 10 && busy !== 1'h1; k++)
      @(negedge mclk);
    req = 1'h0;
    for (k = 0; k < 4000; k++)
    begin
      @(negedge mclk);
      if (rd_valid === 1'h1 && n < 3)
      begin
        got[n] = rd_data;
        n++;
      end
      if (done === 1'h1)
        break;
    end
    check("done", {7'h00, done}, 8'h01);
    got_nack = nack;
  endtask
  task ack_is(input logic e);
    check("nack", {7'h00, got_nack}, {7'h00, e});
  endtask
  // lockout restarts the device; address is taken again at release
  task lockout();
    supply_undervoltage_lockout = 1'h1;
    repeat (3) @(negedge mclk);
    supply_undervoltage_lockout = 1'h0;
    repeat (12) @(negedge mclk);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (20) @(negedge mclk);
    reset_n = 1'h1;
    repeat (12) @(negedge mclk);
    for (int s = 0; s < 4; s++)
    begin
      adr_sel = 2'(s);
      lockout();
      adr_sel = ~adr_sel;
      own = {5'h0b, 2'(s)};
      xfer(own, 1'h0, 8'h00, 2'h0);
      ack_is(1'h0);
      xfer({5'h0b, 2'(s + 1)}, 1'h0, 8'h00, 2'h0);
      ack_is(1'h1);
    end
    xfer(7'h58, 1'h0, 8'h00, 2'h0);
    ack_is(1'h1);
    $display("test address select done");
    xfer(own, 1'h0, 8'h02, 2'h1);
    check("command", cmd, 8'h02);
    xfer(own, 1'h1, 8'h00, 2'h2);
    ack_is(1'h1);
    repeat (500) @(negedge mclk);
    xfer(own, 1'h1, 8'h00, 2'h2);
    ack_is(1'h0);
    check("volt high", got[0], volt[11:4]);
    xfer(own, 1'h0, 8'h08, 2'h1);
    repeat (500) @(negedge mclk);
    xfer(own, 1'h1, 8'h00, 2'h3);
    check("curr low", got[2], curr[7:0]);
    $display("test single conversion done");
    for (int i = 0; i < 2; i++)
    begin
      xfer(own, 1'h0, 8'h05, 2'h1);
      repeat (1200) @(negedge mclk);
      xfer(own, 1'h1, 8'h00, 2'h3);
      ack_is(1'h0);
      check("byte0", got[0], volt[11:4]);
      check("byte1", got[1], {volt[3:0], curr[11:8]});
      check("byte2", got[2], curr[7:0]);
      volt = 12'h123;
      curr = 12'hfe4;
    end
    xfer(own, 1'h0, 8'h81, 2'h1);
    ack_is(1'h0);
    check("command kept", cmd, 8'h05);
    check("strobes", 8'(stb_seen), 8'h04);
    $display("test continuous and extended done");
    check("alert idle", {7'h00, alert_oe}, 8'h01);
    over = 1'h1;
    repeat (8) @(negedge mclk);
    over = 1'h0;
    repeat (8) @(negedge mclk);
    check("alert held", {6'h00, alert_o, alert_oe}, 8'h00);
    xfer(own, 1'h0, 8'h40, 2'h1);
    xfer(own, 1'h1, 8'h00, 2'h1);
    check("status set", got[0], 8'h01);
    clr_n = 1'h0;
    repeat (8) @(negedge mclk);
    clr_n = 1'h1;
    repeat (8) @(negedge mclk);
    check("alert clear", {7'h00, alert_oe}, 8'h01);
    xfer(own, 1'h1, 8'h00, 2'h1);
    check("status clear", got[0], 8'h00);
    over = 1'h1;
    repeat (8) @(negedge mclk);
    over = 1'h0;
    lockout();
    check("alert lockout", {7'h00, alert_oe}, 8'h01);
    $display("test alert flag done");
    test_done();
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    $display("watchdog expired");
    test_done();
  end
endmodule

// ==== verilog/pmon_defs.svh ====
// timing counts, address fields and command fields of the power monitor link
`ifndef PMON_DEFS_SVH
`define PMON_DEFS_SVH
`define ADDR_UPPER 5'h0b
`define ADR_TIED_LOW 2'h0
`define ADR_RES_GND 2'h1
`define ADR_FLOATING 2'h2
`define ADR_TIED_HIGH 2'h3
`define CMD_EXT_BIT 7
`define CMD_V_CONT 0
`define CMD_V_ONCE 1
`define CMD_I_CONT 2
`define CMD_I_ONCE 3
`define CMD_STATUS 6
`define MCLK_PERIOD_NS 40
`define SCL_PERIOD_NS 2560
`define SCL_HALF_CYCLES (`SCL_PERIOD_NS / `MCLK_PERIOD_NS / 2)
`define CONV_TIME_NS 4000
`define CONV_CYCLES ((`CONV_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// ==== verilog/pmon_device.sv ====
// device end: link slave, address select and overcurrent flag
// Notes on behaviour
// - address is 01011 plus two select bits
// - select states map to 0x2c..0x2f
// - address captured once after reset release
// - slave only, link clock from master
// - sda falling while scl high starts
// - shift address msb first, then direction
// - acknowledge low through ninth clock
// - mismatch stays released until next start
// - nine clocks per byte with acknowledge
// - sda rising while scl high stops
// - first written byte is the command
// - master writes before reading; no commands
// - stop after write returns to idle
// - no-acknowledge on read ends driving
// - sda pulled low only, scl input
// - results twelve bits over two bytes
// - one converter, channel chosen per request
// - flag high open-drain on overcurrent
// - low clear input clears latched flag
// - undervoltage lockout holds everything in reset
// - command msb one means extended write
// - nack reads until single conversion completes
`timescale 1ns/10ps
`include "pmon_defs.svh"
module pmon_device
  import pmon_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  pmon_link_if.device LINK,
  input wire logic [1:0] ADR_SEL,
  input wire logic OVERCURRENT,
  input wire logic LATCH_CLEAR_N,
  input wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input wire logic [11:0] VOLT_SAMPLE,
  input wire logic [11:0] CURR_SAMPLE,
  output logic ALERT_O,
  output logic ALERT_OE,
  output logic [7:0] COMMAND,
  output logic COMMAND_STB
);
  // ----------------------------------------------------------------
  // pin synchronisers and reset
  // ----------------------------------------------------------------
  logic rst_n;
  logic scl_s;
  logic sda_s;
  logic [1:0] adr_s;
  logic oc_s;
  logic clr_n_s;
  assign rst_n = RESET_N & ~SUPPLY_UNDERVOLTAGE_LOCKOUT;
  pmon_sync #(.WIDTH(6)) u_sync (
    .clk(MCLK),
    .reset_n(rst_n),
    .d({LINK.scl, LINK.sda, ADR_SEL, OVERCURRENT, LATCH_CLEAR_N}),
    .q({scl_s, sda_s, adr_s, oc_s, clr_n_s})
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    slv_state_e st;
    logic scl_d;
    logic sda_d;
    logic addr_ok;
    logic [1:0] adr_lsb;
    logic [2:0] init;
    logic [3:0] bitn;
    byte_t shreg;
    logic rd;
    logic first;
    logic [1:0] rdidx;
    logic sda_low;
    logic alert;
    byte_t cmd;
    logic cmd_stb;
    logic busy;
    logic chan_i;
    logic [15:0] conv_cnt;
    logic [11:0] volt;
    logic [11:0] curr;
  } dev_s;
  dev_s r_reg, r_next;

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_hit;
  byte_t tx_byte;
  assign scl_rise = scl_s & ~r_reg.scl_d;
  assign scl_fall = ~scl_s & r_reg.scl_d;
  assign start_ev = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
  assign stop_ev = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
  assign addr_hit = r_reg.shreg[7:1] == {`ADDR_UPPER, r_reg.adr_lsb};

  // ----------------------------------------------------------------
  // read data: status alone when CMD_STATUS is set, else voltage then current packed in three bytes
  // ----------------------------------------------------------------
  always_comb
  begin
    tx_byte = 8'h00;
    if (r_reg.cmd[`CMD_STATUS])
      tx_byte = {7'h00, r_reg.alert};
    else
    begin
      case (r_reg.rdidx)
        2'h0: tx_byte = r_reg.volt[11:4];
        2'h1: tx_byte = {r_reg.volt[3:0], r_reg.curr[11:8]};
        2'h2: tx_byte = r_reg.curr[7:0];
        default: tx_byte = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;
    r_next.cmd_stb = 1'b0;
    // settle the synchroniser before taking the select pin once
    if (r_reg.init != 3'h7)
    begin
      r_next.init = r_reg.init + 3'h1;
      if (r_reg.init == 3'h6)
        r_next.adr_lsb = adr_s;
    end
    // overcurrent latch: set wins over clear
    if (oc_s)
      r_next.alert = 1'b1;
    else if (!clr_n_s)
      r_next.alert = 1'b0;
    // conversion engine: one converter, muxed channel
    if (r_reg.busy)
    begin
      if (r_reg.conv_cnt == 16'h0000)
      begin
        r_next.busy = 1'b0;
        if (r_reg.chan_i)
          r_next.curr = CURR_SAMPLE;
        else
          r_next.volt = VOLT_SAMPLE;
        if (!r_reg.chan_i && r_reg.cmd[`CMD_I_ONCE])
        begin
          r_next.busy = 1'b1;
          r_next.chan_i = 1'b1;
          r_next.conv_cnt = 16'(CONV_CYCLES - 1);
        end
      end
      else
        r_next.conv_cnt = r_reg.conv_cnt - 16'h0001;
    end
    else if (r_reg.cmd[`CMD_V_CONT] || r_reg.cmd[`CMD_I_CONT])
    begin
      r_next.busy = 1'b1;
      r_next.chan_i = ~r_reg.cmd[`CMD_V_CONT] |
        (r_reg.cmd[`CMD_I_CONT] & ~r_reg.chan_i);
      r_next.conv_cnt = 16'(CONV_CYCLES - 1);
    end
    // link protocol
    if (start_ev)
    begin
      r_next.st = S_ADDR;
      r_next.bitn = 4'h0;
      r_next.sda_low = 1'b0;
    end
    else if (stop_ev)
    begin
      r_next.st = S_IDLE;
      r_next.sda_low = 1'b0;
    end
    else
    begin
      case (r_reg.st)
        S_IDLE, S_IGNORE: r_next.sda_low = 1'b0;
        S_ADDR, S_RX:
        begin
          if (scl_rise)
          begin
            r_next.shreg = {r_reg.shreg[6:0], sda_s};
            r_next.bitn = r_reg.bitn + 4'h1;
          end
          if (scl_fall && r_reg.bitn == 4'h8)
          begin
            r_next.bitn = 4'h0;
            if (r_reg.st == S_ADDR)
            begin
              r_next.addr_ok = addr_hit;
              r_next.rd = r_reg.shreg[0];
              r_next.first = 1'b1;
              r_next.rdidx = 2'h0;
              // nack reads while a single conversion runs
              if (addr_hit && !(r_reg.shreg[0] && r_reg.busy &&
                  (r_reg.cmd[`CMD_V_ONCE] || r_reg.cmd[`CMD_I_ONCE])))
              begin
                r_next.st = S_ACK;
                r_next.sda_low = 1'b1;
              end
              else
                r_next.st = S_IGNORE;
            end
            else
            begin
              r_next.st = S_ACK;
              r_next.sda_low = 1'b1;
              if (r_reg.first && !r_reg.shreg[`CMD_EXT_BIT])
              begin
                r_next.cmd = r_reg.shreg;
                r_next.cmd_stb = 1'b1;
                if (r_reg.shreg[`CMD_V_ONCE] || r_reg.shreg[`CMD_I_ONCE])
                begin
                  r_next.busy = 1'b1;
                  r_next.chan_i = ~r_reg.shreg[`CMD_V_ONCE];
                  r_next.conv_cnt = 16'(CONV_CYCLES - 1);
                end
              end
              // extended register byte: acked, contents not held
              r_next.first = 1'b0;
            end
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            r_next.sda_low = 1'b0;
            if (r_reg.rd)
            begin
              r_next.st = S_TX;
              r_next.shreg = tx_byte;
              r_next.sda_low = ~tx_byte[7];
              r_next.bitn = 4'h0;
            end
            else
              r_next.st = S_RX;
          end
        end
        S_TX:
        begin
          if (scl_fall)
          begin
            r_next.bitn = r_reg.bitn + 4'h1;
            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
            r_next.sda_low = ~r_reg.shreg[6];
            if (r_reg.bitn == 4'h7)
            begin
              r_next.st = S_RXACK;
              r_next.sda_low = 1'b0;
            end
          end
        end
        S_RXACK:
        begin
          if (scl_rise)
          begin
            r_next.rd = ~sda_s;
            if (!sda_s)
              r_next.rdidx = r_reg.rdidx + 2'h1;
          end
          if (scl_fall)
          begin
            if (r_reg.rd)
            begin
              // next byte must be on sda before the first data rise
              r_next.st = S_TX;
              r_next.shreg = tx_byte;
              r_next.sda_low = ~tx_byte[7];
              r_next.bitn = 4'h0;
            end
            else
              r_next.st = S_IGNORE;
          end
        end
        default: r_next.st = S_IDLE;
      endcase
    end
  end

  // one register stage holds the whole device state
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign LINK.sda_s_o = 1'b0;
  assign LINK.sda_s_oe = r_reg.sda_low;
  assign ALERT_O = 1'b0;
  // open-drain flag: released means pulled high externally
  assign ALERT_OE = ~r_reg.alert;
  assign COMMAND = r_reg.cmd;
  assign COMMAND_STB = r_reg.cmd_stb;
endmodule

// ==== verilog/pmon_host.sv ====
// master end: drives scl by a divider and runs write or read transfers
`timescale 1ns/10ps
`include "pmon_defs.svh"
module pmon_host
  import pmon_pkg::*;
#(
  parameter int HALF = `SCL_HALF_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  pmon_link_if.host LINK,
  input wire logic REQ,
  input wire logic [6:0] REQ_ADDR,
  input wire logic REQ_READ,
  input wire logic [7:0] REQ_DATA,
  input wire logic [1:0] REQ_LEN,
  output logic BUSY,
  output logic DONE,
  output logic NACK,
  output logic [7:0] RD_DATA,
  output logic RD_VALID
);
  logic scl_s;
  logic sda_s;
  pmon_sync #(.WIDTH(2)) u_sync (
    .clk(MCLK),
    .reset_n(RESET_N),
    .d({LINK.scl, LINK.sda}),
    .q({scl_s, sda_s})
  );
  typedef struct packed {
    mst_state_e st;
    logic [7:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    byte_t sh;
    logic first;
    logic rd;
    logic [1:0] left;
    logic scl_low;
    logic sda_low;
    logic busy;
    logic done;
    logic nack;
    byte_t rdata;
    logic rvalid;
  } host_s;
  host_s r_reg, r_next;
  logic tick;
  assign tick = r_reg.cnt == 8'(HALF - 1);

  // ----------------------------------------------------------------
  // transfer sequencer, one phase per half scl period
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.rvalid = 1'b0;
    r_next.cnt = tick ? 8'h00 : r_reg.cnt + 8'h01;
    case (r_reg.st)
      M_IDLE:
      begin
        r_next.cnt = 8'h00;
        if (REQ)
        begin
          r_next.st = M_START;
          r_next.busy = 1'b1;
          r_next.nack = 1'b0;
          r_next.sh = {REQ_ADDR, REQ_READ};
          r_next.rd = REQ_READ;
          r_next.left = REQ_LEN;
          r_next.first = 1'b1;
          r_next.ph = 2'h0;
        end
      end
      M_START:
        if (tick)
        begin
          r_next.ph = r_reg.ph + 2'h1;
          if (r_reg.ph == 2'h0)
            r_next.sda_low = 1'b1;
          else
          begin
            r_next.scl_low = 1'b1;
            r_next.st = M_BIT;
            r_next.bitn = 4'h0;
            r_next.ph = 2'h0;
          end
        end
      M_BIT:
        if (tick)
        begin
          if (r_reg.scl_low)
          begin
            // change data only while scl is low
            r_next.sda_low = (r_reg.first || !r_reg.rd) ? ~r_reg.sh[7]
              : 1'b0;
            r_next.scl_low = 1'b0;
          end
          else
          begin
            r_next.sh = {r_reg.sh[6:0], sda_s};
            r_next.scl_low = 1'b1;
            r_next.bitn = r_reg.bitn + 4'h1;
            if (r_reg.bitn == 4'h7)
              r_next.st = M_ACK;
          end
        end
      M_ACK:
        if (tick)
        begin
          if (r_reg.scl_low)
          begin
            // read data: ack all but the last byte
            r_next.sda_low = !r_reg.first && r_reg.rd &&
              r_reg.left > 2'h1;
            r_next.scl_low = 1'b0;
          end
          else
          begin
            r_next.scl_low = 1'b1;
            if (!r_reg.first && r_reg.rd)
            begin
              r_next.rdata = r_reg.sh;
              r_next.rvalid = 1'b1;
            end
            if ((r_reg.first || !r_reg.rd) && sda_s)
            begin
              r_next.nack = 1'b1;
              r_next.st = M_STOP;
            end
            else if (!r_reg.first && r_reg.left <= 2'h1)
              r_next.st = M_STOP;
            else
            begin
              if (!r_reg.first)
                r_next.left = r_reg.left - 2'h1;
              else if (!r_reg.rd && r_reg.left == 2'h0)
                r_next.st = M_STOP;
              r_next.first = 1'b0;
              r_next.sh = REQ_DATA;
              r_next.bitn = 4'h0;
              if (r_next.st == M_ACK)
                r_next.st = M_BIT;
            end
            r_next.ph = 2'h0;
          end
        end
      M_STOP:
        if (tick)
        begin
          r_next.ph = r_reg.ph + 2'h1;
          case (r_reg.ph)
            2'h0: r_next.sda_low = 1'b1;
            2'h1: r_next.scl_low = 1'b0;
            default:
            begin
              r_next.sda_low = 1'b0;
              r_next.st = M_DONE;
            end
          endcase
        end
      M_DONE:
      begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
        r_next.st = M_IDLE;
      end
      default: r_next.st = M_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign LINK.scl_o = 1'b0;
  assign LINK.scl_oe = r_reg.scl_low;
  assign LINK.sda_m_o = 1'b0;
  assign LINK.sda_m_oe = r_reg.sda_low;
  assign BUSY = r_reg.busy;
  assign DONE = r_reg.done;
  assign NACK = r_reg.nack;
  assign RD_DATA = r_reg.rdata;
  assign RD_VALID = r_reg.rvalid;
endmodule

// ==== verilog/pmon_link_if.sv ====
// open-drain link between the power monitor and its bus master
`timescale 1ns/10ps
interface pmon_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enabled driver whose output is low pulls the line low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe,
    output sda_m_o, output sda_m_oe);
endinterface

// ==== verilog/pmon_pkg.sv ====
// types shared by both ends of the power monitor link
package pmon_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_RXACK, S_IGNORE
  } slv_state_e;
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BIT, M_ACK, M_STOP, M_DONE
  } mst_state_e;
  typedef logic [7:0] byte_t;
endpackage

// ==== verilog/pmon_sync.sv ====
// two-flop synchroniser for pins that come from outside the clock domain
`timescale 1ns/10ps
module pmon_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
